// ===== dplr_params.svh
/*
 * Constants for the dual root port lane configuration and peer router.
 * Assumes it is included by bare name from the package and the design file.
 */
// What this block does
// RULE_01: Primary port function is enabled whenever a card sits in either slot.
// RULE_02: Secondary port clock is gated off while its enable bit is zero.
// RULE_03: Primary function controls primary slot; secondary function controls secondary slot.
// RULE_04: Lane reversal flips all sixteen lanes of both ports as one group.
// RULE_05: Under reversal each physical lane's owner is remapped, logical ownership unchanged.
// RULE_06: Configuration comes only from the straps, never from dynamic detection.
// RULE_07: Straps decode to two x8, one x16, one secondary x8, or none.
// RULE_08: Secondary enable bit resets to 1 when dual strap low, else 0.
// RULE_09: Board pulls each strap low with card present, high when empty.
// RULE_10: Primary-present strap at 0 means a card in the primary slot.
// RULE_11: Peer-to-peer reads between ports are never supported.
// RULE_12: Central path carries hub writes to ports, port writes to hub, fallback.
// RULE_13: Performance path carries port-to-port writes both ways with 36-bit addresses.
// RULE_14: Software disables relaxed ordering while the performance path is used.
// RULE_15: Peer devices must be compliant, without inbound/outbound dependency.
// RULE_16: Performance path writes ignore both ports' power states.
// RULE_17: Central path write to non-fully-on bridge becomes unsupported request.
// RULE_18: With performance path on, range writes route regardless of central path.
// RULE_19: With performance path off, central enable completes writes, else unsupported.
`ifndef DPLR_PARAMS_SVH
`define DPLR_PARAMS_SVH

// Register offsets
`define DPLR_OFS_CTRL      4'h0
`define DPLR_OFS_STATUS    4'h1
`define DPLR_OFS_IRQ_STAT  4'h2
`define DPLR_OFS_IRQ_EN    4'h3
`define DPLR_OFS_IRQ_CLR   4'h4
// Control field positions
`define DPLR_CTRL_SEC_EN   0
`define DPLR_CTRL_CENT_EN  1
`define DPLR_CTRL_PERF_EN  2
`define DPLR_CTRL_REV      3
// Interrupt bit positions
`define DPLR_IRQ_UR        0
`define DPLR_IRQ_READ      1
`define DPLR_IRQ_FWD       2
// Reset values
`define DPLR_CTRL_RST      4'h0
`define DPLR_IRQ_EN_RST    3'h0
`define DPLR_D0            2'h0
// Timing counts
`define DPLR_SYNC_WAIT     2'h2

`endif

// ===== dplr_pkg.sv
/*
 * Types for the dual root port router.
 * Assumes dplr_params.svh is on the include path.
 */
package dplr_pkg;
	`include "dplr_params.svh"

	// Requester and target of a peer transaction
	typedef enum logic [1:0] {
		DPLR_HUB  = 2'h0,
		DPLR_PRI  = 2'h1,
		DPLR_SEC  = 2'h3
	} dplr_port_t;

	// Lane configuration from the straps
	typedef enum logic [1:0] {
		DPLR_CFG_NONE  = 2'h0,
		DPLR_CFG_X16   = 2'h1,
		DPLR_CFG_DUAL  = 2'h3,
		DPLR_CFG_SECX8 = 2'h2
	} dplr_cfg_t;

	// Routing outcome
	typedef enum logic [1:0] {
		DPLR_RT_DROP = 2'h0,
		DPLR_RT_CENT = 2'h1,
		DPLR_RT_PERF = 2'h3,
		DPLR_RT_UR   = 2'h2
	} dplr_route_t;

	// Incoming peer request
	typedef struct packed {
		logic        valid;
		logic        is_write;
		logic        in_range;
		dplr_port_t  src;
		dplr_port_t  dst;
		logic [35:0] addr;
		logic [31:0] data;
	} dplr_req_t;

	// Routed answer
	typedef struct packed {
		logic        valid;
		dplr_route_t route;
		dplr_port_t  dst;
		logic [35:0] addr;
		logic [31:0] data;
	} dplr_fwd_t;
endpackage

// ===== dplr_router.sv
/*
 * Dual root port strap decode, lane ownership, clock gate and peer write router.
 * Assumes straps are board-level pins held stable around reset and a 100 MHz clk_i.
 */
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "dplr_params.svh"

module dplr_router #(
	parameter int LANES = 16
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	// Board straps
	input  wire logic                 dual_port_strap_n_i,
	input  wire logic                 primary_present_strap_n_i,
	input  wire logic                 lane_reverse_i,
	// Port power states
	input  wire logic [1:0]           pri_dstate_i,
	input  wire logic [1:0]           sec_dstate_i,
	// Register port
	input  wire logic [3:0]           reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic [31:0]               reg_rdata_o,
	// Peer traffic
	input  wire dplr_pkg::dplr_req_t  req_i,
	output dplr_pkg::dplr_fwd_t       fwd_o,
	// Configuration outputs
	output logic                      primary_root_port_en_o,
	output logic                      secondary_root_port_en_o,
	output dplr_pkg::dplr_cfg_t       cfg_o,
	output logic                      sec_clk_en_o,
	output logic [LANES-1:0]          lane_owner_sec_o,
	output logic [LANES-1:0]          lane_phys_map_rev_o,
	output logic                      irq_o
);
	import dplr_pkg::*;

	/************************************************************
	 * Strap capture
	 ************************************************************/
	logic       dual_s1_q, dual_s2_q, pri_s1_q, pri_s2_q, rev_s1_q, rev_s2_q;
	logic       latched_q;
	logic [1:0] warm_q;
	logic       dual_n_q, pri_n_q, rev_q;
	logic [3:0] ctrl_q;
	logic [2:0] irq_stat_q, irq_en_q;
	dplr_cfg_t  cfg_q;

	// Two-stage synchronisers; only stage two feeds logic
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dual_s1_q <= 1'b1;
			dual_s2_q <= 1'b1;
			pri_s1_q  <= 1'b1;
			pri_s2_q  <= 1'b1;
			rev_s1_q  <= 1'b0;
			rev_s2_q  <= 1'b0;
		end else begin
			dual_s1_q <= dual_port_strap_n_i;
			dual_s2_q <= dual_s1_q;
			pri_s1_q  <= primary_present_strap_n_i;
			pri_s2_q  <= pri_s1_q;
			rev_s1_q  <= lane_reverse_i;
			rev_s2_q  <= rev_s1_q;
		end
	end

	// Straps are caught once after release; later pin moves are ignored since nothing probes the link
	// Capture waits for both synchroniser stages, so their reset value is never taken as a strap
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			warm_q    <= 2'h0;
			latched_q <= 1'b0;
			dual_n_q  <= 1'b1;
			pri_n_q   <= 1'b1;
			rev_q     <= 1'b0;
		end else if (!latched_q) begin
			if (warm_q == `DPLR_SYNC_WAIT) begin
				latched_q <= 1'b1;
				dual_n_q  <= dual_s2_q; // RULE_06
				pri_n_q   <= pri_s2_q;  // RULE_10
				rev_q     <= rev_s2_q;
			end else begin
				warm_q <= warm_q + 2'h1;
			end
		end
	end

	/************************************************************
	 * Configuration decode
	 ************************************************************/
	// Low strap means a card is present
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_q <= DPLR_CFG_NONE;
		end else if (latched_q) begin
			unique case ({pri_n_q, dual_n_q}) // RULE_07
				2'b00: cfg_q <= DPLR_CFG_DUAL;
				2'b01: cfg_q <= DPLR_CFG_X16;
				2'b10: cfg_q <= DPLR_CFG_SECX8;
				2'b11: cfg_q <= DPLR_CFG_NONE;
			endcase
		end
	end

	assign cfg_o                    = cfg_q;
	// Primary function stays on for any present card
	assign primary_root_port_en_o   = (cfg_q != DPLR_CFG_NONE); // RULE_01
	assign secondary_root_port_en_o = ctrl_q[`DPLR_CTRL_SEC_EN];
	// Gate secondary clock tree with its enable bit
	assign sec_clk_en_o             = ctrl_q[`DPLR_CTRL_SEC_EN]; // RULE_02

	/************************************************************
	 * Lane ownership
	 ************************************************************/
	// Logical lanes 0..7 belong to primary, upper lanes to secondary when both active
	logic [LANES-1:0] log_sec_w;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign log_sec_w[g] = (cfg_q == DPLR_CFG_DUAL) ? (g >= LANES/2) :
			                      (cfg_q == DPLR_CFG_SECX8); // RULE_03
			// Reversal swaps physical index end to end, owner follows the logical lane
			assign lane_owner_sec_o[g]    = ctrl_q[`DPLR_CTRL_REV] ?
			                                log_sec_w[LANES-1-g] : log_sec_w[g]; // RULE_05
			assign lane_phys_map_rev_o[g] = ctrl_q[`DPLR_CTRL_REV]; // RULE_04
		end
	endgenerate

	/************************************************************
	 * Registers
	 ************************************************************/
	logic [2:0] evt;
	logic       seeded_q;

	// Control: secondary enable seeded from strap after capture
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q   <= `DPLR_CTRL_RST;
			seeded_q <= 1'b0;
		end else if (latched_q && !seeded_q) begin
			seeded_q                     <= 1'b1;
			ctrl_q[`DPLR_CTRL_SEC_EN]    <= ~dual_n_q; // RULE_08
			ctrl_q[`DPLR_CTRL_REV]       <= rev_q;
		end else if (reg_wr_i && reg_addr_i == `DPLR_OFS_CTRL) begin
			ctrl_q <= reg_wdata_i[3:0];
		end
	end

	// Sticky status; a new event wins over a same-cycle clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q &
			              ~((reg_wr_i && reg_addr_i == `DPLR_OFS_IRQ_CLR) ? reg_wdata_i[2:0] : 3'h0)) | evt;
		end
	end

	// Interrupt enable
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_en_q <= `DPLR_IRQ_EN_RST;
		end else if (reg_wr_i && reg_addr_i == `DPLR_OFS_IRQ_EN) begin
			irq_en_q <= reg_wdata_i[2:0];
		end
	end

	assign irq_o = |(irq_stat_q & irq_en_q);

	// Read data one cycle after strobe; unmapped reads return zero
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`DPLR_OFS_CTRL:     reg_rdata_o <= {28'h0, ctrl_q};
				`DPLR_OFS_STATUS:   reg_rdata_o <= {28'h0, rev_q, latched_q, cfg_q};
				`DPLR_OFS_IRQ_STAT: reg_rdata_o <= {29'h0, irq_stat_q};
				`DPLR_OFS_IRQ_EN:   reg_rdata_o <= {29'h0, irq_en_q};
				default:            reg_rdata_o <= 32'h0;
			endcase
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

	/************************************************************
	 * Peer routing
	 ************************************************************/
	logic        is_peer, dst_d0, dst_on, cent_ok;
	dplr_route_t route;

	always_comb begin
		is_peer = (req_i.src != DPLR_HUB) && (req_i.dst != DPLR_HUB) && (req_i.src != req_i.dst);
		dst_d0  = (req_i.dst == DPLR_PRI) ? (pri_dstate_i == `DPLR_D0) :
		          (req_i.dst == DPLR_SEC) ? (sec_dstate_i == `DPLR_D0) : 1'b1;
		dst_on  = (req_i.dst == DPLR_SEC) ? ctrl_q[`DPLR_CTRL_SEC_EN] : primary_root_port_en_o;
		cent_ok = ctrl_q[`DPLR_CTRL_CENT_EN] && dst_on;
		route   = DPLR_RT_DROP;
		if (!req_i.valid) begin
			route = DPLR_RT_DROP;
		end else if (!req_i.is_write) begin
			route = DPLR_RT_UR; // RULE_11
		end else if (is_peer && req_i.in_range && ctrl_q[`DPLR_CTRL_PERF_EN] && dst_on) begin
			// Power state ignored; central enable irrelevant here
			route = DPLR_RT_PERF; // RULE_13 RULE_16 RULE_18
		end else if (!cent_ok) begin
			route = DPLR_RT_UR; // RULE_19
		end else if (!dst_d0) begin
			route = DPLR_RT_UR; // RULE_17
		end else begin
			route = DPLR_RT_CENT; // RULE_12
		end
	end

	assign evt[`DPLR_IRQ_UR]   = (route == DPLR_RT_UR) && req_i.is_write;
	assign evt[`DPLR_IRQ_READ] = req_i.valid && !req_i.is_write;
	assign evt[`DPLR_IRQ_FWD]  = (route == DPLR_RT_CENT) || (route == DPLR_RT_PERF);

	// Registered forward; full 36-bit address carried
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fwd_o <= '0;
		end else begin
			fwd_o.valid <= req_i.valid;
			fwd_o.route <= route;
			fwd_o.dst   <= req_i.dst;
			fwd_o.addr  <= req_i.addr; // RULE_13
			fwd_o.data  <= req_i.data;
		end
	end

	/************************************************************
	 * Assertions: straps and lanes
	 ************************************************************/
	// Synchroniser full, capture pending
	sequence s_capture;
		!latched_q && (warm_q == `DPLR_SYNC_WAIT);
	endsequence

	// Capture lands, seeding follows on the next edge
	sequence s_seed;
		latched_q && !seeded_q ##1 seeded_q;
	endsequence

	// Straps are taken once, only after the synchroniser filled
	AST_CAPTURE_ORDER: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_06
		s_capture |=> s_seed)
		else $error("strap capture and seeding out of order");

	// Frozen straps never move after capture
	AST_CFG_STABLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_06
		$past(latched_q) && latched_q |=> $stable(dual_n_q) && $stable(pri_n_q))
		else $error("straps resampled after capture");

	// Primary function on for a card in either slot
	AST_PRI_EN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_01
		(latched_q && (!pri_n_q || !dual_n_q)) |=> primary_root_port_en_o)
		else $error("primary function off with card present");

	// Low primary strap always gives a decode with a primary card
	AST_PRI_SLOT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_10
		(latched_q && !pri_n_q) |=> (cfg_q == DPLR_CFG_X16 || cfg_q == DPLR_CFG_DUAL))
		else $error("primary card not seen");

	// Each strap pair decodes to its own configuration
	AST_DUAL: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
		(latched_q && !pri_n_q && !dual_n_q) |=> (cfg_q == DPLR_CFG_DUAL))
		else $error("both straps low not dual");

	AST_X16: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
		(latched_q && !pri_n_q && dual_n_q) |=> (cfg_q == DPLR_CFG_X16))
		else $error("primary strap alone not x16");

	AST_SECX8: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
		(latched_q && pri_n_q && !dual_n_q) |=> (cfg_q == DPLR_CFG_SECX8))
		else $error("secondary strap alone not secondary x8");

	AST_NONE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_07
		(latched_q && pri_n_q && dual_n_q) |=> (cfg_q == DPLR_CFG_NONE))
		else $error("no straps low but a port decoded");

	// Secondary enable seeded from the dual strap
	AST_SEC_SEED: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_08
		(latched_q && !seeded_q) |=> (ctrl_q[`DPLR_CTRL_SEC_EN] == ~$past(dual_n_q)))
		else $error("secondary enable reset value wrong");

	// Gated clock follows the secondary enable
	AST_CLK_GATE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_02
		!secondary_root_port_en_o |-> !sec_clk_en_o)
		else $error("secondary clock running while disabled");

	// Single x16 port: no lane belongs to the secondary function
	AST_OWN_X16: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_03
		(cfg_q == DPLR_CFG_X16) |-> (lane_owner_sec_o == '0))
		else $error("x16 lane owned by secondary");

	// Secondary only: every lane belongs to the secondary function
	AST_OWN_SECX8: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_03
		(cfg_q == DPLR_CFG_SECX8) |-> (&lane_owner_sec_o))
		else $error("secondary lane owned by primary");

	// Reversal covers every lane as one group
	AST_REV_ALL: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_04
		lane_phys_map_rev_o == {LANES{ctrl_q[`DPLR_CTRL_REV]}})
		else $error("lane reversal not uniform");

	// Reversed dual: owners swap ends
	AST_REV: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_05
		ctrl_q[`DPLR_CTRL_REV] && cfg_q == DPLR_CFG_DUAL |-> lane_owner_sec_o[0] && !lane_owner_sec_o[LANES-1])
		else $error("reversed lane owner wrong");

	/************************************************************
	 * Assertions: peer routing
	 ************************************************************/
	// Reads are always refused
	AST_READ_UR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_11
		(req_i.valid && !req_i.is_write) |=> (fwd_o.route == DPLR_RT_UR))
		else $error("peer read not refused");

	// A refused read raises its flag, even beside a clear
	AST_READ_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_11
		(req_i.valid && !req_i.is_write) |=> irq_stat_q[`DPLR_IRQ_READ])
		else $error("refused read not flagged");

	// Every request is answered one edge later
	AST_FWD_VALID: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
		req_i.valid |=> fwd_o.valid)
		else $error("request not answered");

	// Full address carried unchanged
	AST_ADDR36: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_13
		req_i.valid |=> (fwd_o.addr == $past(req_i.addr)))
		else $error("forwarded address altered");

	// Write data carried unchanged
	AST_DATA: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
		req_i.valid |=> (fwd_o.data == $past(req_i.data)))
		else $error("forwarded data altered");

	// Performance path ignores power state
	AST_PERF: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_16
		(req_i.valid && req_i.is_write && is_peer && req_i.in_range && dst_on && ctrl_q[`DPLR_CTRL_PERF_EN])
		|=> (fwd_o.route == DPLR_RT_PERF))
		else $error("performance write not forwarded");

	// Performance path ignores the central enable
	AST_PERF_ANY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_18
		(req_i.valid && req_i.is_write && is_peer && req_i.in_range && dst_on && ctrl_q[`DPLR_CTRL_PERF_EN]
		&& !ctrl_q[`DPLR_CTRL_CENT_EN]) |=> (fwd_o.route == DPLR_RT_PERF))
		else $error("performance write held by central enable");

	// Hub traffic takes the central path when it is open
	AST_CENT_FWD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_12
		(req_i.valid && req_i.is_write && !is_peer && cent_ok && dst_d0)
		|=> (fwd_o.route == DPLR_RT_CENT && fwd_o.dst == $past(req_i.dst)))
		else $error("central write not forwarded");

	// Both paths off: writes are refused
	AST_CENT_OFF: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_19
		(req_i.valid && req_i.is_write && !ctrl_q[`DPLR_CTRL_PERF_EN] && !ctrl_q[`DPLR_CTRL_CENT_EN])
		|=> (fwd_o.route == DPLR_RT_UR))
		else $error("write completed with both paths off");

	// Refused write is flagged, set beats a clear
	AST_UR_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_19
		(req_i.valid && req_i.is_write && !ctrl_q[`DPLR_CTRL_PERF_EN] && !ctrl_q[`DPLR_CTRL_CENT_EN])
		|=> irq_stat_q[`DPLR_IRQ_UR])
		else $error("refused write not flagged");

	// Central write to a sleeping bridge is refused
	AST_DSTATE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE_17
		(req_i.valid && req_i.is_write && !dst_d0 && route != DPLR_RT_PERF) |=> (fwd_o.route == DPLR_RT_UR))
		else $error("central write to sleeping bridge accepted");
endmodule // dplr_router

// ===== dplr_board_model.sv
/*
 * Board model: slot presence straps seen by the router.
 * Assumes the bench sets slot contents while the router is held in reset.
 */
`timescale 1ns/1ps
module dplr_board_model (
	// Slot contents
	input  wire logic pri_card_i,
	input  wire logic sec_card_i,
	// Strap pins toward the router
	output logic      primary_present_strap_n_o,
	output logic      dual_port_strap_n_o
);
	// Presence pins pull low with a card and high when empty, never float
	assign primary_present_strap_n_o = !pri_card_i;
	assign dual_port_strap_n_o       = !sec_card_i;
endmodule // dplr_board_model

// ===== dual_port_lane_config_peer_router_bench.sv
/*
 * Self-checking bench: strap decode, lane map, registers, interrupt, peer routing.
 * Assumes dplr_pkg and dplr_router are compiled first; clock is 100 MHz.
 */
`timescale 1ns/1ps
module dual_port_lane_config_peer_router_bench;
	import dplr_pkg::*;
	// ************
	// Signals
	// ************
	logic        clk_i, reset_n_i, pri_card, sec_card, lane_reverse_i, reg_wr_i, reg_rd_i;
	logic [1:0]  pri_dstate_i, sec_dstate_i;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o;
	logic        pri_strap_n, sec_strap_n, pri_en, sec_en, sec_clk_en, irq_o;
	logic [15:0] owner_sec, map_rev;
	dplr_req_t   req_i;
	dplr_fwd_t   fwd_o;
	dplr_cfg_t   cfg_o;
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;

	dplr_board_model board (.pri_card_i(pri_card), .sec_card_i(sec_card),
		.primary_present_strap_n_o(pri_strap_n), .dual_port_strap_n_o(sec_strap_n));
	dplr_router #(.LANES(16)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .dual_port_strap_n_i(sec_strap_n),
		.primary_present_strap_n_i(pri_strap_n), .lane_reverse_i(lane_reverse_i), .pri_dstate_i(pri_dstate_i),
		.sec_dstate_i(sec_dstate_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .fwd_o(fwd_o),
		.primary_root_port_en_o(pri_en), .secondary_root_port_en_o(sec_en), .cfg_o(cfg_o),
		.sec_clk_en_o(sec_clk_en), .lane_owner_sec_o(owner_sec), .lane_phys_map_rev_o(map_rev), .irq_o(irq_o));

	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count = err_count + 1;
			end_sim();
		end
	end

	// ************
	// Shared tasks
	// ************
	task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Straps are set while reset is held and sampled after release; six edges cover capture and seeding
	task automatic do_reset(logic p, logic s, logic rev);
		reset_n_i <= 1'b0;
		pri_card <= p;
		sec_card <= s;
		lane_reverse_i <= rev;
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask

	task automatic reg_wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic settle();
		@(posedge clk_i);
		#1;
	endtask

	// One request cycle, answer judged in the following cycle
	task automatic peer(logic wr, dplr_port_t s, dplr_port_t t, dplr_route_t exp);
		dplr_req_t r;
		r = '{valid: 1'b1, is_write: wr, in_range: 1'b1, src: s, dst: t, addr: 36'h8_1234_5678, data: 32'hA5C3_0F1E};
		@(posedge clk_i);
		// Requests carry no relaxed ordering and never wait on inbound answers
		req_i <= r;
		@(posedge clk_i);
		req_i.valid <= 1'b0;
		#1;
		check("fwd_valid", fwd_o.valid, 1'b1);
		check("fwd_route", fwd_o.route, exp);
		if (exp != DPLR_RT_UR) begin
			check("fwd_dst", fwd_o.dst, t);
			check("fwd_addr", fwd_o.addr, r.addr);
			check("fwd_data", fwd_o.data, r.data);
		end
	endtask

	// ************
	// Scenarios
	// ************
	task automatic test_straps();
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			do_reset(i[0], i[1], 1'b0);
			check("cfg", cfg_o, i[1:0]);
			check("pri_en", pri_en, i[0] | i[1]);
			check("sec_en", sec_en, i[1]);
			check("sec_clk", sec_clk_en, i[1]);
			check("pri_present", cfg_o == DPLR_CFG_X16 || cfg_o == DPLR_CFG_DUAL, i[0]);
			if (i == 3) check("owner_dual", owner_sec, 16'hFF00);
			if (i == 2) check("owner_secx8", owner_sec, 16'hFFFF);
			if (i == 1) check("owner_x16", owner_sec, 16'h0000);
			reg_rd(4'h0, d);
			check("ctrl_reset", d, i[1]);
			reg_rd(4'h1, d);
			check("status", d, 32'h4 | i[1:0]);
		end
	endtask

	task automatic test_reverse();
		logic [31:0] d;
		do_reset(1'b1, 1'b1, 1'b1);
		check("map_rev", map_rev, 16'hFFFF);
		check("owner_rev", owner_sec, 16'h00FF);
		reg_rd(4'h0, d);
		check("ctrl_rev", d, 32'h9);
		reg_wr(4'h0, 32'h1);
		settle();
		check("map_fwd", map_rev, 16'h0000);
		check("owner_fwd", owner_sec, 16'hFF00);
		// Straps moving after reset must not reconfigure anything
		@(posedge clk_i);
		pri_card <= 1'b0;
		sec_card <= 1'b0;
		lane_reverse_i <= 1'b0;
		repeat (4) settle();
		check("cfg_held", cfg_o, DPLR_CFG_DUAL);
	endtask

	task automatic test_peer();
		do_reset(1'b1, 1'b1, 1'b0);
		reg_wr(4'h0, 32'h5);
		@(posedge clk_i);
		pri_dstate_i <= 2'h3;
		sec_dstate_i <= 2'h3;
		peer(1'b1, DPLR_PRI, DPLR_SEC, DPLR_RT_PERF);
		peer(1'b1, DPLR_SEC, DPLR_PRI, DPLR_RT_PERF);
		peer(1'b0, DPLR_PRI, DPLR_SEC, DPLR_RT_UR);
		peer(1'b1, DPLR_HUB, DPLR_SEC, DPLR_RT_UR);
		reg_wr(4'h0, 32'h3);
		peer(1'b1, DPLR_HUB, DPLR_SEC, DPLR_RT_UR);
		@(posedge clk_i);
		pri_dstate_i <= 2'h0;
		sec_dstate_i <= 2'h0;
		peer(1'b1, DPLR_HUB, DPLR_SEC, DPLR_RT_CENT);
		peer(1'b1, DPLR_HUB, DPLR_PRI, DPLR_RT_CENT);
		peer(1'b1, DPLR_SEC, DPLR_HUB, DPLR_RT_CENT);
		peer(1'b1, DPLR_PRI, DPLR_SEC, DPLR_RT_CENT);
		reg_wr(4'h0, 32'h1);
		peer(1'b1, DPLR_PRI, DPLR_SEC, DPLR_RT_UR);
		reg_wr(4'h0, 32'h7);
		peer(1'b1, DPLR_PRI, DPLR_SEC, DPLR_RT_PERF);
	endtask

	// Sticky status, enable mask, write-one clear, read-only and unmapped places
	task automatic test_irq();
		logic [31:0] d;
		do_reset(1'b1, 1'b1, 1'b0);
		reg_wr(4'h3, 32'h1);
		peer(1'b1, DPLR_HUB, DPLR_PRI, DPLR_RT_UR);
		settle();
		check("irq_set", irq_o, 1'b1);
		reg_rd(4'h2, d);
		check("irq_stat", d, 32'h1);
		reg_wr(4'h3, 32'h2);
		settle();
		check("irq_mask", irq_o, 1'b0);
		reg_wr(4'h3, 32'h1);
		reg_wr(4'h2, 32'h0);
		reg_rd(4'h2, d);
		check("stat_ro", d, 32'h1);
		settle();
		check("rdata_idle", reg_rdata_o, 32'h0);
		reg_wr(4'h4, 32'h1);
		settle();
		check("irq_clr", irq_o, 1'b0);
		reg_rd(4'hF, d);
		check("unmapped", d, 32'h0);
		// A refused read and the clear of its flag in one cycle: the event wins
		fork
			reg_wr(4'h4, 32'h2);
			peer(1'b0, DPLR_PRI, DPLR_SEC, DPLR_RT_UR);
		join
		reg_rd(4'h2, d);
		check("set_wins", d, 32'h2);
	endtask

	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		pri_card = 1'b0;
		sec_card = 1'b0;
		lane_reverse_i = 1'b0;
		pri_dstate_i = 2'h0;
		sec_dstate_i = 2'h0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 32'h0;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		req_i = '0;
		test_straps();
		$display("test straps done");
		test_reverse();
		$display("test reverse done");
		test_peer();
		$display("test peer done");
		test_irq();
		$display("test irq done");
		end_sim();
	end
endmodule // dual_port_lane_config_peer_router_bench
